// ===== core/cpts_pkg.sv
package cpts_pkg;
  localparam logic [11:0] CPTS_ADDR_STATUS    = 12'h000;
  localparam logic [11:0] CPTS_ADDR_CORE_CTRL = 12'h004;
  localparam logic [11:0] CPTS_ADDR_INT_CTRL1 = 12'h008;
  localparam logic [11:0] CPTS_ADDR_IRQ_STAT  = 12'h00c;
  localparam logic [11:0] CPTS_ADDR_IRQ_MASK  = 12'h010;
  localparam int CPTS_PRIO_LSB    = 5;
  localparam int CPTS_PRIO_MSB    = 7;
  localparam int CPTS_HIGH_BIT    = 3;
  localparam int CPTS_NEST_BIT    = 15;
  localparam int CPTS_ARITH_BIT   = 4;
  localparam int CPTS_ADDR_BIT    = 3;
  localparam int CPTS_STACK_BIT   = 2;
  localparam int CPTS_OSC_BIT     = 1;
  localparam int CPTS_NFAULT      = 4;
  localparam logic [2:0] CPTS_PRIO_RESET  = 3'h0;
  localparam logic [2:0] CPTS_PRIO_MAX    = 3'h7;
  localparam logic [15:0] CPTS_WORD_ZERO  = 16'h0000;
  localparam logic [31:0] CPTS_RDATA_ZERO = 32'h0000_0000;
  // fault order inside the packed vector: arith, addr, stack, osc
  typedef struct packed {
    logic arith;
    logic addr;
    logic stack;
    logic osc;
  } cpts_fault_t;
  typedef enum logic [1:0] {
    CPTS_IDLE   = 2'b01,
    CPTS_ACCESS = 2'b10
  } cpts_state_t;
endpackage

// ===== core/cpts_fault_flags.sv
`timescale 1ns/100ps
module cpts_fault_flags
  import cpts_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire cpts_fault_t fault_evt,
  input  wire cpts_fault_t clr_req,
  output      cpts_fault_t flags
);
  logic [CPTS_NFAULT-1:0] flag_ff;
  logic [CPTS_NFAULT-1:0] evt_v;
  logic [CPTS_NFAULT-1:0] clr_v;
  assign evt_v = fault_evt;
  assign clr_v = clr_req;
  assign flags = flag_ff;
  // set wins over clear so a trap coincident with a software clear is kept
  genvar gi;
  generate
    for (gi = 0; gi < CPTS_NFAULT; gi++) begin : g_flag
      logic nxt_flag;
      assign nxt_flag = evt_v[gi] | (flag_ff[gi] & ~clr_v[gi]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_ff[gi] <= 1'b0;
        end else begin
          flag_ff[gi] <= nxt_flag;
        end
      end
      a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        flag_ff[gi] && !clr_v[gi] |=> flag_ff[gi]) else $error("fault flag dropped without clear");
      a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        evt_v[gi] |=> flag_ff[gi]) else $error("fault event not recorded");
    end
  endgenerate
endmodule

// ===== core/cpts_core.sv
`timescale 1ns/100ps
module cpts_core
  import cpts_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire cpts_fault_t trap_evt,
  input  wire logic        trap_entry,
  input  wire logic [2:0]  trap_prio,
  output      logic [3:0]  cpu_level,
  output      logic        user_irq_masked,
  output      logic        irq
);
  cpts_state_t         state_ff;
  cpts_state_t         nxt_state;
  logic [2:0]          prio_ff;
  logic [2:0]          nxt_prio;
  logic                high_ff;
  logic                nxt_high;
  logic                nest_ff;
  logic                nxt_nest;
  logic [CPTS_NFAULT-1:0] irq_stat_ff;
  logic [CPTS_NFAULT-1:0] nxt_irq_stat;
  logic [CPTS_NFAULT-1:0] irq_mask_ff;
  logic [CPTS_NFAULT-1:0] nxt_irq_mask;
  logic [31:0]         prdata_ff;
  logic                pready_ff;
  logic                pslverr_ff;
  logic [3:0]          level_ff;
  logic                umask_ff;
  logic                irq_ff;
  cpts_fault_t         flags;
  cpts_fault_t         flag_clr;
  logic                setup;
  logic                wr_en;
  logic                rd_en;
  logic                sel_status;
  logic                sel_core;
  logic                sel_ctrl1;
  logic                sel_istat;
  logic                sel_imask;
  logic                mapped;
  logic                lo_we;
  logic                hi_we;
  logic [15:0]         status_word;
  logic [15:0]         core_word;
  logic [15:0]         ctrl1_word;
  logic [15:0]         rd_word;
  logic [3:0]          nxt_level;

  // two-cycle APB: setup then access answered with pready in the same access cycle
  assign setup      = psel && !penable && (state_ff == CPTS_IDLE);
  assign wr_en      = (state_ff == CPTS_ACCESS) && psel && penable && pwrite && mapped;
  assign rd_en      = setup && !pwrite;
  assign sel_status = (paddr == CPTS_ADDR_STATUS);
  assign sel_core   = (paddr == CPTS_ADDR_CORE_CTRL);
  assign sel_ctrl1  = (paddr == CPTS_ADDR_INT_CTRL1);
  assign sel_istat  = (paddr == CPTS_ADDR_IRQ_STAT);
  assign sel_imask  = (paddr == CPTS_ADDR_IRQ_MASK);
  assign mapped     = sel_status | sel_core | sel_ctrl1 | sel_istat | sel_imask;
  assign lo_we      = wr_en && pstrb[0];
  assign hi_we      = wr_en && pstrb[1];

  // unimplemented positions are tied to zero in the read words
  always_comb begin
    status_word = CPTS_WORD_ZERO;
    status_word[CPTS_PRIO_MSB:CPTS_PRIO_LSB] = prio_ff;
    core_word = CPTS_WORD_ZERO;
    core_word[CPTS_HIGH_BIT] = high_ff;
    ctrl1_word = CPTS_WORD_ZERO;
    ctrl1_word[CPTS_NEST_BIT]  = nest_ff;
    ctrl1_word[CPTS_ARITH_BIT] = flags.arith;
    ctrl1_word[CPTS_ADDR_BIT]  = flags.addr;
    ctrl1_word[CPTS_STACK_BIT] = flags.stack;
    ctrl1_word[CPTS_OSC_BIT]   = flags.osc;
  end

  assign rd_word = sel_status ? status_word :
                   sel_core   ? core_word   :
                   sel_ctrl1  ? ctrl1_word  :
                   sel_istat  ? {12'h000, irq_stat_ff} :
                   sel_imask  ? {12'h000, irq_mask_ff} : CPTS_WORD_ZERO;

  // a trap entry raises the level into the 8..15 band, which software cannot reach
  assign nxt_prio = trap_entry ? trap_prio :
                    (lo_we && sel_status && !nest_ff) ?
                    pwdata[CPTS_PRIO_MSB:CPTS_PRIO_LSB] : prio_ff;
  // writing 1 to the high bit has no effect; only 0 clears it
  assign nxt_high = trap_entry ? 1'b1 :
                    (lo_we && sel_core && !pwdata[CPTS_HIGH_BIT]) ? 1'b0 : high_ff;
  assign nxt_nest = (hi_we && sel_ctrl1) ? pwdata[CPTS_NEST_BIT] : nest_ff;

  // software clears a fault flag by writing 0 to it
  assign flag_clr.arith = lo_we && sel_ctrl1 && !pwdata[CPTS_ARITH_BIT];
  assign flag_clr.addr  = lo_we && sel_ctrl1 && !pwdata[CPTS_ADDR_BIT];
  assign flag_clr.stack = lo_we && sel_ctrl1 && !pwdata[CPTS_STACK_BIT];
  assign flag_clr.osc   = lo_we && sel_ctrl1 && !pwdata[CPTS_OSC_BIT];

  // read of the irq status register clears it; a new event in that cycle still lands
  assign nxt_irq_stat = trap_evt | (irq_stat_ff & ~((rd_en && sel_istat) ? {CPTS_NFAULT{1'b1}} : {CPTS_NFAULT{1'b0}}));
  assign nxt_irq_mask = (lo_we && sel_imask) ? pwdata[CPTS_NFAULT-1:0] : irq_mask_ff;
  assign nxt_level    = {nxt_high, nxt_prio};

  always_comb begin
    case (state_ff)
      CPTS_IDLE:   nxt_state = setup ? CPTS_ACCESS : CPTS_IDLE;
      CPTS_ACCESS: nxt_state = CPTS_IDLE;
      default:     nxt_state = CPTS_IDLE;
    endcase
  end

  cpts_fault_flags u_flags (
    .pclk      (pclk),
    .presetn   (presetn),
    .fault_evt (trap_evt),
    .clr_req   (flag_clr),
    .flags     (flags)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= CPTS_IDLE;
      prio_ff     <= CPTS_PRIO_RESET;
      high_ff     <= 1'b0;
      nest_ff     <= 1'b0;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
    end else begin
      state_ff    <= nxt_state;
      prio_ff     <= nxt_prio;
      high_ff     <= nxt_high;
      nest_ff     <= nxt_nest;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= CPTS_RDATA_ZERO;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= rd_en ? {16'h0000, rd_word} : CPTS_RDATA_ZERO;
      pready_ff  <= setup;
      pslverr_ff <= setup && !mapped;
    end
  end

  // outputs registered; level tracks the register in the same cycle, loaded from the same next values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_ff <= 4'h0;
      umask_ff <= 1'b0;
      irq_ff   <= 1'b0;
    end else begin
      level_ff <= nxt_level;
      umask_ff <= (nxt_level >= {1'b0, CPTS_PRIO_MAX});
      irq_ff   <= |(nxt_irq_stat & nxt_irq_mask);
    end
  end

  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign cpu_level       = level_ff;
  assign user_irq_masked = umask_ff;
  assign irq             = irq_ff;

  // the bus walk has two steps, setup then access; naming them keeps the handshake checks readable
  sequence s_setup;
    psel && !penable && (state_ff == CPTS_IDLE);
  endsequence

  sequence s_answer;
    pready && (state_ff == CPTS_ACCESS);
  endsequence

  a_prio_locked: assert property (@(posedge pclk) disable iff (!presetn)
    nest_ff && !trap_entry |=> $stable(prio_ff))
    else $error("priority changed while nesting disabled");

  a_high_no_set: assert property (@(posedge pclk) disable iff (!presetn)
    !high_ff && !trap_entry |=> !high_ff)
    else $error("high priority bit set by software");

  a_trap_load: assert property (@(posedge pclk) disable iff (!presetn)
    trap_entry |=> high_ff && (prio_ff == $past(trap_prio)))
    else $error("trap entry did not raise the level");

  a_level_track: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 cpu_level == {high_ff, prio_ff})
    else $error("level output not equal to joined fields");

  a_level7_mask: assert property (@(posedge pclk) disable iff (!presetn)
    user_irq_masked == (cpu_level >= {1'b0, CPTS_PRIO_MAX}))
    else $error("user mask wrong for level");

  a_umask_band: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_level > {1'b0, CPTS_PRIO_MAX} |-> user_irq_masked)
    else $error("trap band level not masking users");

  a_prio_write: assert property (@(posedge pclk) disable iff (!presetn)
    lo_we && sel_status && !nest_ff && !trap_entry |=> prio_ff == $past(pwdata[CPTS_PRIO_MSB:CPTS_PRIO_LSB]))
    else $error("priority write lost");

  a_high_clear: assert property (@(posedge pclk) disable iff (!presetn)
    lo_we && sel_core && !pwdata[CPTS_HIGH_BIT] && !trap_entry |=> !high_ff)
    else $error("high priority bit not cleared");

  a_nest_write: assert property (@(posedge pclk) disable iff (!presetn)
    hi_we && sel_ctrl1 |=> nest_ff == $past(pwdata[CPTS_NEST_BIT]))
    else $error("nesting disable write lost");

  a_nest_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(hi_we && sel_ctrl1) |=> $stable(nest_ff))
    else $error("nesting disable changed without write");

  // the status and control one read words are also checked through the bus, so a wrong mux leg for them shows up here
  a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pslverr |-> prdata[31:16] == 16'h0000)
    else $error("unused read bits nonzero");

  a_status_zero: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[15:CPTS_PRIO_MSB+1] == '0 && status_word[CPTS_PRIO_LSB-1:0] == '0)
    else $error("status unused bits nonzero");

  a_core_zero: assert property (@(posedge pclk) disable iff (!presetn)
    core_word == ({15'h0000, high_ff} << CPTS_HIGH_BIT))
    else $error("core control unused bits nonzero");

  a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel_status |=> prdata[15:0] == $past(status_word))
    else $error("status read data wrong");

  a_ctrl1_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && sel_ctrl1 |=> prdata[15:0] == $past(ctrl1_word))
    else $error("control one read data wrong");

  a_high_reads: assert property (@(posedge pclk) disable iff (!presetn)
    high_ff |-> core_word[CPTS_HIGH_BIT])
    else $error("high bit not visible");

  a_stack_bit: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl1_word[CPTS_STACK_BIT] == flags.stack)
    else $error("stack flag position wrong");

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup |=> s_answer)
    else $error("no answer in the access cycle");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !mapped |=> pslverr)
    else $error("unmapped access without error");

  a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    setup && mapped |=> !pslverr)
    else $error("mapped access flagged as error");

  a_idle_data: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == CPTS_RDATA_ZERO)
    else $error("read data outside the answer cycle");

  // event wins over the read clear, so a trap in the clearing cycle is never lost
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(irq_stat_ff & irq_mask_ff))
    else $error("irq does not follow masked status");

  a_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    !(rd_en && sel_istat) |=> (irq_stat_ff & $past(irq_stat_ff)) == $past(irq_stat_ff))
    else $error("irq status dropped without read");

  a_stat_event: assert property (@(posedge pclk) disable iff (!presetn)
    |trap_evt |=> (irq_stat_ff & $past(trap_evt)) == $past(trap_evt))
    else $error("trap event missing from irq status");
endmodule

// ===== tb/cpts_trap_model.sv
`timescale 1ns/100ps
module cpts_trap_model
  import cpts_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire cpts_fault_t fire_req,
  input  wire logic        entry_req,
  input  wire logic [2:0]  prio_req,
  output      cpts_fault_t trap_evt,
  output      logic        trap_entry,
  output      logic [2:0]  trap_prio
);
  cpts_fault_t evt_ff;
  logic        entry_ff;
  logic [2:0]  prio_ff;
  // prio is only meaningful with entry, so it toggles otherwise to expose a stale sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_ff   <= '0;
      entry_ff <= 1'b0;
      prio_ff  <= 3'h0;
    end else begin
      evt_ff   <= fire_req;
      entry_ff <= entry_req;
      prio_ff  <= entry_req ? prio_req : ~prio_ff;
    end
  end
  assign trap_evt   = evt_ff;
  assign trap_entry = entry_ff;
  assign trap_prio  = prio_ff;
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import cpts_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, entry_req, er, user_irq_masked, irq, trap_entry, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, wd;
  logic [3:0]  pstrb, cpu_level, msk;
  logic [2:0]  prio_req, trap_prio;
  logic [7:0]  lfsr_ff;
  cpts_fault_t fire_req, trap_evt;
  int bad_count, n_checks;
  cpts_trap_model i_model (.pclk(pclk), .presetn(presetn), .fire_req(fire_req), .entry_req(entry_req),
    .prio_req(prio_req), .trap_evt(trap_evt), .trap_entry(trap_entry), .trap_prio(trap_prio));
  cpts_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trap_evt(trap_evt), .trap_entry(trap_entry), .trap_prio(trap_prio), .cpu_level(cpu_level),
    .user_irq_masked(user_irq_masked), .irq(irq));
  function automatic logic [7:0] lfsr_nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] exp_status(input logic [2:0] f);
    return {24'h000000, f, 5'h00};
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, g);
    end
  endtask
  // apb master: request held until pready is sampled high, bounded wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("[ERR] pready exp 1 seen %b", pready);
      close_out();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0); chk(nm, e, rd); chk("pslverr", 32'h0, {31'h0, er});
  endtask
  task automatic fire(input cpts_fault_t v, input logic en, input logic [2:0] p);
    @(posedge pclk); fire_req <= v; entry_req <= en; prio_req <= p;
    @(posedge pclk); fire_req <= '0; entry_req <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  initial begin pclk = 1'b0; forever #10 pclk = ~pclk; end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    pstrb = 4'hf; fire_req = '0; entry_req = 1'b0; prio_req = 3'h0; lfsr_ff = 8'h3e;
    bad_count = 0; n_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk(CPTS_ADDR_STATUS, 32'h0, "status rst");
    rchk(CPTS_ADDR_CORE_CTRL, 32'h0, "core rst");
    rchk(CPTS_ADDR_INT_CTRL1, 32'h0, "int1 rst");
    for (int v = 0; v < 8; v++) begin
      lfsr_ff = lfsr_nx(lfsr_ff);
      wd = {4{lfsr_ff}};
      wd[7:5] = 3'(v);
      apb(1'b1, CPTS_ADDR_STATUS, wd);
      rchk(CPTS_ADDR_STATUS, exp_status(3'(v)), "status field");
      chk("cpu_level", {28'h0, 1'b0, 3'(v)}, {28'h0, cpu_level});
      chk("masked", {31'h0, v == 7}, {31'h0, user_irq_masked});
    end
    apb(1'b1, CPTS_ADDR_CORE_CTRL, 32'hffff_ffff);
    rchk(CPTS_ADDR_CORE_CTRL, 32'h0, "high bit set by sw");
    fire('0, 1'b1, 3'h5);
    rchk(CPTS_ADDR_CORE_CTRL, 32'h8, "high bit trap");
    rchk(CPTS_ADDR_STATUS, exp_status(3'h5), "trap field");
    chk("cpu_level trap", 32'hd, {28'h0, cpu_level});
    apb(1'b1, CPTS_ADDR_CORE_CTRL, 32'h0);
    rchk(CPTS_ADDR_CORE_CTRL, 32'h0, "high bit clear");
    apb(1'b1, CPTS_ADDR_INT_CTRL1, 32'hffff_ffff);
    rchk(CPTS_ADDR_INT_CTRL1, 32'h8000, "nest only");
    apb(1'b1, CPTS_ADDR_STATUS, 32'h0000_0040);
    rchk(CPTS_ADDR_STATUS, exp_status(3'h5), "nest locks field");
    chk("cpu_level nest", 32'h5, {28'h0, cpu_level});
    apb(1'b1, CPTS_ADDR_INT_CTRL1, 32'h0);
    for (int k = 0; k < 4; k++) begin
      lfsr_ff = lfsr_nx(lfsr_ff);
      msk = lfsr_ff[3:0];
      // force the fired source masked on odd passes and unmasked on even ones, so irq is seen both ways
      msk[k] = (k % 2 == 0);
      apb(1'b1, CPTS_ADDR_IRQ_MASK, {28'h0, msk});
      fire(cpts_fault_t'(4'h1 << k), 1'b0, 3'h0);
      chk("irq", {31'h0, |(msk & (4'h1 << k))}, {31'h0, irq});
      rchk(CPTS_ADDR_INT_CTRL1, 32'h1 << (k + 1), "fault flag");
      apb(1'b1, CPTS_ADDR_INT_CTRL1, 32'h0000_001e);
      rchk(CPTS_ADDR_INT_CTRL1, 32'h1 << (k + 1), "flag write 1");
      rchk(CPTS_ADDR_IRQ_STAT, 32'h1 << k, "irq status");
      rchk(CPTS_ADDR_IRQ_STAT, 32'h0, "irq read clear");
      chk("irq clear", 32'h0, {31'h0, irq});
      apb(1'b1, CPTS_ADDR_INT_CTRL1, 32'h0);
      rchk(CPTS_ADDR_INT_CTRL1, 32'h0, "flag clear");
    end
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    close_out();
  end
endmodule
